// *** logic/acj_unit.sv ***
`timescale 1ns/1ps
module acj_unit #(
  parameter int PC_W = acj_pkg::PC_BITS
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire logic                  clk_en,
  input  wire logic                  cmd_valid,
  input  wire acj_pkg::acj_cmd_s     cmd,
  input  wire logic                  standalone_mode,
  input  wire acj_pkg::acj_inputs_s  inputs,
  input  wire acj_pkg::acj_errors_s  errors,
  output logic                       reply_valid,
  output acj_pkg::acj_reply_s        reply,
  output logic [31:0]                accumulator,
  output acj_pkg::acj_flags_s        flags,
  output logic [PC_W-1:0]            program_counter,
  output logic                       pc_load
);
  typedef struct packed {
    logic [31:0]          acc;
    acj_pkg::acj_flags_s  flags;
    logic [PC_W-1:0]      pc;
    logic                 pc_load;
    logic                 reply_valid;
    acj_pkg::acj_reply_s  reply;
  } acj_state_s;

  acj_state_s   state_r;
  acj_state_s   state_nxt;
  logic [31:0]  operand;
  logic [31:0]  input_value;
  logic         input_ok;

  assign operand = cmd.value_bytes;

  acj_input_mux u_input_mux (
    .inputs (inputs),
    .port   (cmd.cmd_type),
    .bank   (cmd.bank),
    .value  (input_value),
    .valid  (input_ok)
  );

  function automatic logic [31:0] arith(input logic [31:0] a, input logic [31:0] b,
                                        input logic [3:0] op, output logic ok);
    logic signed [31:0] sa;
    logic signed [31:0] sb;
    sa = a;
    sb = b;
    ok = 1'b1;
    arith = a;
    case (acj_pkg::acj_arith_e'(op))
      acj_pkg::OP_ADD:      arith = a + b;
      acj_pkg::OP_SUB:      arith = a - b;
      acj_pkg::op_multiply: arith = 32'(sa * sb);
      acj_pkg::OP_DIV:      arith = (b == 32'h0000_0000) ? a : 32'(sa / sb);
      acj_pkg::op_modulo:   arith = (b == 32'h0000_0000) ? a : 32'(sa % sb);
      acj_pkg::OP_AND:      arith = a & b;
      acj_pkg::OP_OR:       arith = a | b;
      acj_pkg::OP_XOR:      arith = a ^ b;
      acj_pkg::OP_NOT:      arith = ~a;
      acj_pkg::OP_LOAD:     arith = b;
      default: begin
        arith = a;
        ok = 1'b0;
      end
    endcase
  endfunction

  function automatic logic cond_met(input logic [3:0] c, input acj_pkg::acj_flags_s f,
                                    input acj_pkg::acj_errors_s e, output logic ok);
    ok = 1'b1;
    case (acj_pkg::acj_cond_e'(c))
      acj_pkg::cond_zero:            cond_met = f.zero;
      acj_pkg::cond_not_zero:        cond_met = !f.zero;
      acj_pkg::cond_equal:           cond_met = f.equal;
      acj_pkg::cond_not_equal:       cond_met = !f.equal;
      acj_pkg::cond_greater:         cond_met = f.greater;
      acj_pkg::cond_greater_equal:   cond_met = f.greater || f.equal;
      acj_pkg::cond_lower:           cond_met = f.lower;
      acj_pkg::cond_lower_equal:     cond_met = f.lower || f.equal;
      acj_pkg::timeout_error_flag:   cond_met = e.timeout;
      acj_pkg::external_alarm_flag:  cond_met = e.alarm;
      acj_pkg::deviation_error_flag: cond_met = e.deviation;
      acj_pkg::position_error_flag:  cond_met = e.position;
      default: begin
        cond_met = 1'b0;
        ok = 1'b0;
      end
    endcase
  endfunction

  always_comb begin
    logic        ok;
    logic        take;
    logic [31:0] res;
    ok = 1'b1;
    take = 1'b0;
    res = 32'h0000_0000;
    state_nxt = state_r;
    state_nxt.reply_valid = 1'b0;
    state_nxt.pc_load = 1'b0;
    if (cmd_valid) begin
      state_nxt.reply_valid = !standalone_mode;
      state_nxt.reply.instr = cmd.instr;
      state_nxt.reply.status = acj_pkg::STATUS_OK;
      state_nxt.reply.value = operand;
      case (cmd.instr)
        acj_pkg::INSTR_INPUT_READ: begin
          state_nxt.reply.value = input_value;
          if (!input_ok) begin
            state_nxt.reply.status = acj_pkg::STATUS_BAD_TYPE;
          end else if (standalone_mode || cmd.cmd_type == acj_pkg::PORT_ALL_INPUTS) begin
            state_nxt.acc = input_value;
          end
        end
        acj_pkg::INSTR_ARITH: begin
          res = arith(state_r.acc, operand, cmd.cmd_type[3:0], ok);
          if (ok && cmd.cmd_type[7:4] == 4'h0) begin
            state_nxt.acc = res;
            state_nxt.reply.status = acj_pkg::STATUS_OK;
          end else begin
            state_nxt.reply.status = acj_pkg::STATUS_BAD_TYPE;
          end
        end
        acj_pkg::INSTR_COMPARE: begin
          state_nxt.flags.zero    = (state_r.acc == operand);
          state_nxt.flags.equal   = (state_r.acc == operand);
          state_nxt.flags.greater = ($signed(state_r.acc) > $signed(operand));
          state_nxt.flags.lower   = ($signed(state_r.acc) < $signed(operand));
        end
        acj_pkg::INSTR_COND_JUMP: begin
          take = cond_met(cmd.cmd_type[3:0], state_r.flags, errors, ok);
          if (!ok || cmd.cmd_type[7:4] != 4'h0) begin
            state_nxt.reply.status = acj_pkg::STATUS_BAD_TYPE;
          end else if (take) begin
            state_nxt.pc = operand[PC_W-1:0];
            state_nxt.pc_load = 1'b1;
          end
        end
        default: begin
          state_nxt.reply.status = acj_pkg::STATUS_BAD_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= '{acc: acj_pkg::ACC_RESET, flags: '0, pc: '0, pc_load: 1'b0,
                   reply_valid: 1'b0, reply: '0};
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  assign accumulator     = state_r.acc;
  assign flags           = state_r.flags;
  assign program_counter = state_r.pc;
  assign pc_load         = state_r.pc_load;
  assign reply_valid     = state_r.reply_valid;
  assign reply           = state_r.reply;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence arith_cmd_s;
    clk_en && cmd_valid && cmd.instr == acj_pkg::INSTR_ARITH;
  endsequence

  AST_ARITH_LOAD: assert property (arith_cmd_s and (cmd.cmd_type == 8'h09) |=> accumulator == $past(operand))
    else $error("load did not place operand in accumulator");
  AST_ARITH_ADD: assert property (arith_cmd_s and (cmd.cmd_type == 8'h00)
                                  |=> accumulator == 32'($past(state_r.acc) + $past(operand)))
    else $error("add result wrong");
  AST_DIV_ZERO: assert property (arith_cmd_s and (cmd.cmd_type inside {8'h03, 8'h04}) && operand == 32'h0
                                 |=> $stable(accumulator))
    else $error("divide by zero changed accumulator");
  AST_ARITH_REPLY: assert property (arith_cmd_s and !standalone_mode && cmd.cmd_type < 8'h0A
                                    |=> reply_valid && reply.status == acj_pkg::STATUS_OK)
    else $error("arithmetic reply not OK");
  AST_DIRECT_READ_KEEPS: assert property (clk_en && cmd_valid && cmd.instr == acj_pkg::INSTR_INPUT_READ
                                          && !standalone_mode && cmd.cmd_type != acj_pkg::PORT_ALL_INPUTS
                                          |=> $stable(accumulator))
    else $error("direct input read changed accumulator");
  AST_ALL_INPUTS: assert property (clk_en && cmd_valid && cmd.instr == acj_pkg::INSTR_INPUT_READ
                                   && cmd.bank == 8'h00 && cmd.cmd_type == 8'hFF
                                   |=> accumulator == {29'h0, $past(inputs.digital)})
    else $error("input vector not loaded");
  AST_DIGITAL_BIT: assert property (cmd.bank == 8'h00 && cmd.cmd_type < 8'h03 |-> input_value[31:1] == 31'h0)
    else $error("digital read not 0 or 1");
  AST_COMPARE_EQUAL: assert property (clk_en && cmd_valid && cmd.instr == acj_pkg::INSTR_COMPARE
                                   |=> flags.equal == ($past(state_r.acc) == $past(operand)))
    else $error("compare flag wrong");
  AST_JUMP_NOT_TAKEN: assert property (clk_en && cmd_valid && cmd.instr == acj_pkg::INSTR_COND_JUMP
                                       && cmd.cmd_type == 8'h02 && !flags.equal
                                       |=> !pc_load && $stable(program_counter))
    else $error("jump taken without condition");
  AST_JUMP_ERROR: assert property (clk_en && cmd_valid && cmd.instr == acj_pkg::INSTR_COND_JUMP
                                   && cmd.cmd_type == 8'h08 && errors.timeout
                                   |=> pc_load && program_counter == $past(operand[PC_W-1:0]))
    else $error("timeout jump not taken");
endmodule

// *** include/acj_pkg.sv ***
package acj_pkg;
  // Instruction numbers
  localparam logic [7:0] INSTR_INPUT_READ  = 8'h0F;
  localparam logic [7:0] INSTR_ARITH       = 8'h13;
  localparam logic [7:0] INSTR_COMPARE     = 8'h14;
  localparam logic [7:0] INSTR_COND_JUMP   = 8'h15;
  // Reply status codes
  localparam logic [7:0] STATUS_OK         = 8'h64;
  localparam logic [7:0] STATUS_BAD_CMD    = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE   = 8'h03;
  // Input banks and ports
  localparam logic [7:0] BANK_DIGITAL      = 8'h00;
  localparam logic [7:0] BANK_ANALOG       = 8'h01;
  localparam logic [7:0] PORT_ALL_INPUTS   = 8'hFF;
  localparam logic [7:0] PORT_ANALOG_ZERO  = 8'h00;
  localparam logic [7:0] PORT_SUPPLY       = 8'h08;
  localparam logic [7:0] PORT_TEMPERATURE  = 8'h09;
  localparam int         NUM_INPUTS        = 3;
  localparam int         ADC_BITS          = 12;
  localparam int         PC_BITS           = 16;
  localparam logic [31:0] ACC_RESET        = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, op_multiply, OP_DIV, op_modulo, OP_AND, OP_OR, OP_XOR, OP_NOT, OP_LOAD
  } acj_arith_e;

  typedef enum logic [3:0] {
    cond_zero, cond_not_zero, cond_equal, cond_not_equal, cond_greater, cond_greater_equal,
    cond_lower, cond_lower_equal, timeout_error_flag, external_alarm_flag,
    deviation_error_flag, position_error_flag
  } acj_cond_e;

  // Command frame fields, value bytes MSB first
  typedef struct packed {
    logic [7:0] instr;
    logic [7:0] cmd_type;
    logic [7:0] bank;
    logic [3:0][7:0] value_bytes;
  } acj_cmd_s;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  instr;
    logic [31:0] value;
  } acj_reply_s;

  typedef struct packed {
    logic [ADC_BITS-1:0] analog_zero;
    logic [15:0]         supply_dv;
    logic signed [15:0]  temperature_c;
    logic [NUM_INPUTS-1:0] digital;
  } acj_inputs_s;

  typedef struct packed {
    logic zero;
    logic equal;
    logic greater;
    logic lower;
  } acj_flags_s;

  typedef struct packed {
    logic timeout;
    logic alarm;
    logic deviation;
    logic position;
  } acj_errors_s;
endpackage

// *** logic/acj_input_mux.sv ***
`timescale 1ns/1ps
module acj_input_mux (
  input  wire acj_pkg::acj_inputs_s inputs,
  input  wire logic [7:0]           port,
  input  wire logic [7:0]           bank,
  output logic [31:0]               value,
  output logic                      valid
);
  // Digital and analog views come from separate input fields, bank selects which one is read
  always_comb begin
    value = 32'h0000_0000;
    valid = 1'b0;
    if (bank == acj_pkg::BANK_DIGITAL) begin
      if (port == acj_pkg::PORT_ALL_INPUTS) begin
        value = {{(32-acj_pkg::NUM_INPUTS){1'b0}}, inputs.digital};
        valid = 1'b1;
      end else if (port < 8'(acj_pkg::NUM_INPUTS)) begin
        value = {31'h0000_0000, inputs.digital[port[1:0]]};
        valid = 1'b1;
      end
    end else if (bank == acj_pkg::BANK_ANALOG) begin
      case (port)
        acj_pkg::PORT_ANALOG_ZERO: begin
          value = {{(32-acj_pkg::ADC_BITS){1'b0}}, inputs.analog_zero};
          valid = 1'b1;
        end
        acj_pkg::PORT_SUPPLY: begin
          value = {16'h0000, inputs.supply_dv};
          valid = 1'b1;
        end
        acj_pkg::PORT_TEMPERATURE: begin
          value = {{16{inputs.temperature_c[15]}}, inputs.temperature_c};
          valid = 1'b1;
        end
        default: begin
          value = 32'h0000_0000;
          valid = 1'b0;
        end
      endcase
    end
  end
endmodule

// *** sim/acj_host_model.sv ***
`timescale 1ns/1ps
module acj_host_model (
  input  wire logic         mclk,
  output acj_pkg::acj_cmd_s cmd,
  output logic              cmd_valid,
  output logic              standalone_mode
);
  initial begin
    cmd             = '0;
    cmd_valid       = 1'b0;
    standalone_mode = 1'b0;
  end

  // One frame per call, held until the taking edge, then released
  task automatic send(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bnk,
                      input logic [31:0] val, input logic sa);
    @(posedge mclk);
    cmd_valid       <= 1'b1;
    cmd             <= {ins, typ, bnk, val};
    standalone_mode <= sa;
    @(posedge mclk);
    cmd_valid       <= 1'b0;
    cmd             <= ~{ins, typ, bnk, val};
  endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic                  mclk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  clk_en = 1'b1;
  acj_pkg::acj_cmd_s     cmd;
  logic                  cmd_valid;
  logic                  sa;
  acj_pkg::acj_inputs_s  inputs = '0;
  acj_pkg::acj_errors_s  errors = '0;
  logic                  reply_valid;
  logic                  pc_load;
  acj_pkg::acj_reply_s   reply;
  logic [31:0]           acc;
  acj_pkg::acj_flags_s   flags;
  logic [15:0]           pc;
  int                    fail_count = 0;
  int                    num_checks = 0;
  int                    seed = 59547;
  logic signed [31:0]    acc_m = 32'h0000_0000;
  logic signed [31:0]    op;
  logic [31:0]           e;
  logic [15:0]           pc_m = 16'h0000;
  logic                  tk;
  logic                  ok;
  logic [7:0]            ports [8] = '{8'h00, 8'h01, 8'h02, 8'hFF, 8'h00, 8'h08, 8'h09, 8'h05};
  logic [7:0]            banks [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

  always #10 mclk = ~mclk;

  acj_host_model host_u (.mclk(mclk), .cmd(cmd), .cmd_valid(cmd_valid), .standalone_mode(sa));

  acj_unit dut_u (
    .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd),
    .standalone_mode(sa), .inputs(inputs), .errors(errors), .reply_valid(reply_valid),
    .reply(reply), .accumulator(acc), .flags(flags), .program_counter(pc), .pc_load(pc_load)
  );

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Fresh random inputs and error levels ride along with every command
  task automatic issue(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bnk,
                       input logic [31:0] val, input logic s);
    @(posedge mclk);
    inputs <= 47'({$random(seed), $random(seed)});
    errors <= 4'($random(seed));
    host_u.send(ins, typ, bnk, val, s);
    #1;
  endtask

  function automatic logic [31:0] accumulator_arith_cmd(input int t, input logic signed [31:0] a, input logic signed [31:0] b);
    case (t)
      0: return a + b;
      1: return a - b;
      2: return a * b;
      3: return (b == 0) ? a : a / b;
      4: return (b == 0) ? a : a % b;
      5: return a & b;
      6: return a | b;
      7: return a ^ b;
      8: return ~a;
      default: return b;
    endcase
  endfunction

  initial begin
    #(20 * 3000);
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      for (int t = 0; t < 10; t++) begin
        op = (r == 2 && (t == 3 || t == 4)) ? 32'h0000_0000 : $random(seed);
        issue(acj_pkg::INSTR_ARITH, 8'(t), 8'h00, op, r == 1);
        acc_m = accumulator_arith_cmd(t, acc_m, op);
        chk_val(acc, acc_m, "acc arith");
        chk_bit(reply_valid, r != 1, "reply pulse");
        if (r != 1) chk_val({24'h0, reply.status}, {24'h0, acj_pkg::STATUS_OK}, "arith status");
        if (r != 1) chk_val({24'h0, reply.instr}, {24'h0, acj_pkg::INSTR_ARITH}, "arith instr");
      end
    end
    for (int r = 0; r < 4; r++) begin
      op = (r == 0) ? acc_m : $random(seed);
      issue(acj_pkg::INSTR_COMPARE, 8'h00, 8'h00, op, 1'b1);
      chk_bit(flags.equal, acc_m == op, "equal");
      chk_bit(flags.zero, acc_m == op, "zero");
      chk_bit(flags.greater, acc_m > op, "greater");
      chk_bit(flags.lower, acc_m < op, "lower");
      for (int t = 0; t < 12; t++) begin
        e = {16'h0, 16'($random(seed))};
        issue(acj_pkg::INSTR_COND_JUMP, 8'(t), 8'h00, e, 1'b1);
        case (t)
          0, 2: tk = acc_m == op;
          1, 3: tk = acc_m != op;
          4: tk = acc_m > op;
          5: tk = acc_m >= op;
          6: tk = acc_m < op;
          7: tk = acc_m <= op;
          8: tk = errors.timeout;
          9: tk = errors.alarm;
          10: tk = errors.deviation;
          default: tk = errors.position;
        endcase
        if (tk) pc_m = e[15:0];
        chk_bit(pc_load, tk, "jump taken");
        chk_val({16'h0, pc}, {16'h0, pc_m}, "pc");
      end
    end
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 8; i++) begin
        issue(acj_pkg::INSTR_INPUT_READ, ports[i], banks[i], 32'h0000_0000, s == 1);
        ok = 1'b1;
        case (i)
          0, 1, 2: e = {31'h0, inputs.digital[i]};
          3: e = {29'h0, inputs.digital};
          4: e = {20'h0, inputs.analog_zero};
          5: e = {16'h0, inputs.supply_dv};
          6: e = {{16{inputs.temperature_c[15]}}, inputs.temperature_c};
          default: ok = 1'b0;
        endcase
        if (ok && (s == 1 || i == 3)) acc_m = e;
        chk_val(acc, acc_m, "acc read");
        chk_bit(reply_valid, s == 0, "read reply");
        if (s == 0 && ok) chk_val(reply.value, e, "read value");
        if (s == 0 && !ok) chk_val({24'h0, reply.status}, {24'h0, acj_pkg::STATUS_BAD_TYPE}, "bad port");
      end
    end
    // Refused commands and types keep the accumulator
    issue(8'h16, 8'h00, 8'h00, 32'h0000_0001, 1'b0);
    chk_val({24'h0, reply.status}, {24'h0, acj_pkg::STATUS_BAD_CMD}, "bad command");
    chk_val(acc, acc_m, "acc after bad command");
    issue(acj_pkg::INSTR_ARITH, 8'h0A, 8'h00, 32'h0000_0001, 1'b0);
    chk_val({24'h0, reply.status}, {24'h0, acj_pkg::STATUS_BAD_TYPE}, "bad arith type");
    chk_val(acc, acc_m, "acc after bad type");
    issue(acj_pkg::INSTR_COND_JUMP, 8'h0C, 8'h00, 32'h0000_0077, 1'b0);
    chk_val({24'h0, reply.status}, {24'h0, acj_pkg::STATUS_BAD_TYPE}, "bad jump type");
    chk_bit(pc_load, 1'b0, "bad jump taken");
    // Clock enable low drops the command
    @(posedge mclk);
    clk_en <= 1'b0;
    issue(acj_pkg::INSTR_ARITH, 8'h09, 8'h00, 32'h0000_1234, 1'b0);
    chk_val(acc, acc_m, "acc frozen");
    chk_bit(reply_valid, 1'b0, "reply frozen");
    // Reset in mid-run clears all outputs
    @(posedge mclk);
    clk_en <= 1'b1;
    rst_b  <= 1'b0;
    @(posedge mclk);
    #1;
    chk_val(acc, 32'h0000_0000, "acc in reset");
    chk_val({15'h0, pc_load, pc}, 32'h0000_0000, "pc in reset");
    chk_val({27'h0, reply_valid, flags}, 32'h0000_0000, "flags in reset");
    chk_val({16'h0, reply.status, reply.instr}, 32'h0000_0000, "reply in reset");
    @(posedge mclk);
    rst_b <= 1'b1;
    acc_m = 32'h0000_0000;
    op = $random(seed);
    issue(acj_pkg::INSTR_ARITH, 8'h00, 8'h00, op, 1'b0);
    acc_m = accumulator_arith_cmd(0, acc_m, op);
    chk_val(acc, acc_m, "add after reset");
    chk_bit(reply_valid, 1'b1, "reply after reset");
    report_and_stop();
  end
endmodule
